/* File: pkg/tccc_pkg.sv */
// Purpose: Shared constants and types for the timer channel clock and clear control
// Assumes: 125 MHz core_clk, APB register access with 32-bit data
// Notes:   Prescale and clear encodings follow the per-channel select tables
package tccc_pkg;

  localparam int CH_NUM = 6;
  localparam int CNT_W  = 16;
  localparam int REG_W  = 8;
  localparam int DIV_W  = 12;
  localparam int PIN_N  = 4;
  localparam int CLK_MHZ = 125;

  // Register byte offsets; count_control of channel n sits at OFS_CTRL0 + 4*n
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_START = 8'h18;
  localparam logic [7:0] OFS_SYNC  = 8'h1C;
  localparam logic [7:0] OFS_MODE  = 8'h20;
  localparam logic [7:0] OFS_CNT0  = 8'h40;

  // Reset values
  localparam logic [REG_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [5:0]       START_RST = 6'h00;
  localparam logic [5:0]       SYNC_RST  = 6'h00;
  localparam logic [11:0]      MODE_RST  = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_RST   = 12'h000;

  // Field positions inside count_control
  localparam int CLR_MSB  = 7;
  localparam int CLR_LSB  = 5;
  localparam int EDGE_MSB = 4;
  localparam int EDGE_LSB = 3;
  localparam int SEL_MSB  = 2;
  localparam int SEL_LSB  = 0;
  localparam logic [REG_W-1:0] CTRL_MASK_NARROW = 8'h7F;

  // Mode register: bits 1,2,4,5 = phase counting on that channel, upper bits = C/D buffer flags
  localparam logic [11:0] MODE_WMASK = 12'hF36;
  localparam int MODE_BUFC0 = 8;
  localparam int MODE_BUFD0 = 9;
  localparam int MODE_BUFC3 = 10;
  localparam int MODE_BUFD3 = 11;

  // Clear source codes
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] CLR_SYNC_LOW = 2'h3;

  typedef enum logic [3:0] {
    SRC_DIV1    = 4'h0,
    SRC_DIV4    = 4'h1,
    SRC_DIV16   = 4'h2,
    SRC_DIV64   = 4'h3,
    SRC_DIV256  = 4'h4,
    SRC_DIV1024 = 4'h5,
    SRC_DIV4096 = 4'h6,
    SRC_EXT_A   = 4'h8,
    SRC_EXT_B   = 4'h9,
    SRC_EXT_C   = 4'hA,
    SRC_EXT_D   = 4'hB,
    SRC_CASCADE = 4'hF
  } tccc_src_type;

  // Clock source decode per channel and select code
  function automatic tccc_src_type tccc_src_of(input int ch, input logic [2:0] sel);
    tccc_src_type s;
    s = SRC_DIV1;
    case (sel)
      3'h0: s = SRC_DIV1;
      3'h1: s = SRC_DIV4;
      3'h2: s = SRC_DIV16;
      3'h3: s = SRC_DIV64;
      3'h4: s = SRC_EXT_A;
      3'h5: s = (ch == 0 || ch == 1 || ch == 2) ? SRC_EXT_B :
                (ch == 3) ? SRC_DIV1024 : SRC_EXT_C;
      3'h6: s = (ch == 0 || ch == 2) ? SRC_EXT_C :
                (ch == 4) ? SRC_DIV1024 : SRC_DIV256;
      default: s = (ch == 0 || ch == 5) ? SRC_EXT_D : (ch == 2) ? SRC_DIV1024 :
                   (ch == 3) ? SRC_DIV4096 : SRC_CASCADE;
    endcase
    return s;
  endfunction : tccc_src_of

endpackage : tccc_pkg

/* File: pkg/tccc_cnt_if.sv */
// Purpose: Carrier between the control top and one channel counter
// Assumes: One instance per channel, all on core_clk
// Notes:   Strobes are single-cycle, combinational from the top
`timescale 1ns/1ps
interface tccc_cnt_if;
  import tccc_pkg::*;
  logic             cnt_up;
  logic             cnt_dn;
  logic [REG_W-1:0] ctrl;
  logic [3:0]       match;
  logic             sync_en;
  logic             buf_c;
  logic             buf_d;
  logic             sync_clr_in;
  logic             own_clr;
  logic             ovf;
  logic             unf;
  logic [CNT_W-1:0] count;

  modport top  (output cnt_up, cnt_dn, ctrl, match, sync_en, buf_c, buf_d, sync_clr_in,
                input own_clr, ovf, unf, count);
  modport chan (input cnt_up, cnt_dn, ctrl, match, sync_en, buf_c, buf_d, sync_clr_in,
                output own_clr, ovf, unf, count);
endinterface : tccc_cnt_if

/* File: design/tccc_pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for one clock pin
// Assumes: Pin is asynchronous to core_clk
// Notes:   A pin held high through reset shows one rise after release
`timescale 1ns/1ps
module tccc_pin_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Pin and filtered view
  input  wire logic pin,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);
  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic       lvl_ff;
  logic       nxt_lvl;
  logic       rise_ff;
  logic       nxt_rise;
  logic       fall_ff;
  logic       nxt_fall;

  always_comb
  begin
    nxt_stage = {stage_ff[1:0], pin};
    // Only the later two stages take part in the decision
    nxt_lvl   = (stage_ff[1] == stage_ff[2]) ? stage_ff[2] : lvl_ff;
    nxt_rise  = nxt_lvl & ~lvl_ff;
    nxt_fall  = ~nxt_lvl & lvl_ff;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_ff <= 3'h0;
      lvl_ff   <= 1'b0;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
    end
    else
    begin
      stage_ff <= nxt_stage;
      lvl_ff   <= nxt_lvl;
      rise_ff  <= nxt_rise;
      fall_ff  <= nxt_fall;
    end
  end

  assign lvl  = lvl_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;
endmodule : tccc_pin_sync

/* File: design/tccc_chan.sv */
// Purpose: One channel counter with its clear source selection
// Assumes: Count strobes already qualified by start bit and clock selection
// Notes:   Clear wins over a count in the same cycle
`timescale 1ns/1ps
module tccc_chan import tccc_pkg::*; #(
  parameter int CH = 0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to the control top
  tccc_cnt_if.chan cif
);
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic [2:0]       clr_code;
  logic             own_clr;
  logic             sync_hit;

  always_comb
  begin
    clr_code = cif.ctrl[CLR_MSB:CLR_LSB];
    // A buffered C or D register never matches, so it never clears
    case (clr_code)
      CLR_A:   own_clr = cif.match[0];
      CLR_B:   own_clr = cif.match[1];
      CLR_C:   own_clr = cif.match[2] & ~cif.buf_c;
      CLR_D:   own_clr = cif.match[3] & ~cif.buf_d;
      default: own_clr = 1'b0;
    endcase
    sync_hit = (clr_code[1:0] == CLR_SYNC_LOW) & cif.sync_en & cif.sync_clr_in;
    nxt_count = count_ff;
    if (own_clr || sync_hit)
      nxt_count = CNT_RST;
    else if (cif.cnt_up)
      nxt_count = count_ff + 16'h0001;
    else if (cif.cnt_dn)
      nxt_count = count_ff - 16'h0001;
    cif.own_clr = own_clr;
    cif.ovf     = cif.cnt_up & ~own_clr & ~sync_hit & (count_ff == 16'hFFFF);
    cif.unf     = cif.cnt_dn & ~own_clr & ~sync_hit & (count_ff == 16'h0000);
    cif.count   = count_ff;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_ff <= CNT_RST;
    else
      count_ff <= nxt_count;
  end
endmodule : tccc_chan

/* File: design/tccc_top.sv */
// Purpose: Clock source, edge and clear control for a six-channel timer unit
// Assumes: APB slave on core_clk; pins and match events as described in ports
// Notes:   How it works is summarised below
// How it works
// - Six control registers, one per channel
// - Channels 0,3 clear on A, B, C, D
// - Codes 011/111 follow synchronous group clearing
// - Both-edge mode counts rising and falling
// - Phase counting overrides edge select
// - Internal edges only for divide-by-4 and slower
// - Each channel picks its source independently
// - Eight-bit control register, three fields, reset zero
// - General and I/O register counts per channel
// - Common start and synchronous registers exist
// - Only sync-enabled channels join group clearing
// - Buffered C or D never clears
// - Edge code 00/01/1x per source type
// - Bit 7 reserved on channels 1,2,4,5
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module tccc_top import tccc_pkg::*; (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // External clock pins A to D
  input  wire logic [PIN_N-1:0]         ext_clk_pin,
  // Compare or capture events, four per channel (A,B,C,D), one-cycle pulses
  input  wire logic [CH_NUM*4-1:0]      match_evt,
  // Counter values, channel n at bits n*16 upward
  output logic      [CH_NUM*CNT_W-1:0]  channel_counter_flat
);

  // Reset release
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Registers
  logic [REG_W-1:0] ctrl_ff [CH_NUM];
  logic [REG_W-1:0] nxt_ctrl [CH_NUM];
  logic [5:0]       start_ff;
  logic [5:0]       nxt_start;
  logic [5:0]       sync_ff;
  logic [5:0]       nxt_sync;
  logic [11:0]      mode_ff;
  logic [11:0]      nxt_mode;
  logic [31:0]      prdata_ff;
  logic [31:0]      nxt_prdata;
  logic             pready_ff;
  logic             nxt_pready;
  logic             pslverr_ff;
  logic             nxt_pslverr;

  // Decode
  logic             setup;
  logic             wr_go;
  logic             hit;
  logic [31:0]      rd_data;
  logic [CNT_W-1:0] cnt_val [CH_NUM];

  always_comb
  begin
    setup   = psel & ~penable;
    wr_go   = psel & penable & pready_ff & pwrite;
    hit     = 1'b0;
    rd_data = 32'h0000_0000;
    if (paddr[1:0] == 2'h0)
    begin
      for (int i = 0; i < CH_NUM; i++)
      begin
        if (paddr == OFS_CTRL0 + 8'(4 * i))
        begin
          hit     = 1'b1;
          rd_data = {24'h000000, ctrl_ff[i]};
        end
        if (paddr == OFS_CNT0 + 8'(4 * i))
        begin
          hit     = 1'b1;
          rd_data = {16'h0000, cnt_val[i]};
        end
      end
      if (paddr == OFS_START)
      begin
        hit     = 1'b1;
        rd_data = {26'h0000000, start_ff};
      end
      if (paddr == OFS_SYNC)
      begin
        hit     = 1'b1;
        rd_data = {26'h0000000, sync_ff};
      end
      if (paddr == OFS_MODE)
      begin
        hit     = 1'b1;
        rd_data = {20'h00000, mode_ff};
      end
    end
  end

  always_comb
  begin
    nxt_start = start_ff;
    nxt_sync  = sync_ff;
    nxt_mode  = mode_ff;
    for (int i = 0; i < CH_NUM; i++)
    begin
      nxt_ctrl[i] = ctrl_ff[i];
      if (wr_go && paddr == OFS_CTRL0 + 8'(4 * i))
      begin
        // Reserved top bit stays zero on the narrow channels
        if (i == 0 || i == 3)
          nxt_ctrl[i] = pwdata[REG_W-1:0];
        else
          nxt_ctrl[i] = pwdata[REG_W-1:0] & CTRL_MASK_NARROW;
      end
    end
    if (wr_go && paddr == OFS_START)
      nxt_start = pwdata[5:0];
    if (wr_go && paddr == OFS_SYNC)
      nxt_sync = pwdata[5:0];
    if (wr_go && paddr == OFS_MODE)
      nxt_mode = pwdata[11:0] & MODE_WMASK;
    // Answer in the cycle after setup; zero wait in access phase
    nxt_pready  = setup;
    nxt_pslverr = setup & ~hit;
    nxt_prdata  = setup ? rd_data : prdata_ff;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CH_NUM; i++)
        ctrl_ff[i] <= CTRL_RST;
      start_ff   <= START_RST;
      sync_ff    <= SYNC_RST;
      mode_ff    <= MODE_RST;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < CH_NUM; i++)
        ctrl_ff[i] <= nxt_ctrl[i];
      start_ff   <= nxt_start;
      sync_ff    <= nxt_sync;
      mode_ff    <= nxt_mode;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // Prescaler; divider bits act as the prescaled clocks
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic [DIV_W-1:0] div_prev_ff;
  logic [6:0]       int_rise;
  logic [6:0]       int_fall;

  always_comb
  begin
    nxt_div     = div_ff + 12'h001;
    int_rise[0] = 1'b1;
    int_fall[0] = 1'b1;
    for (int k = 1; k < 7; k++)
    begin
      int_rise[k] = div_ff[2*k-1] & ~div_prev_ff[2*k-1];
      int_fall[k] = ~div_ff[2*k-1] & div_prev_ff[2*k-1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff      <= DIV_RST;
      div_prev_ff <= DIV_RST;
    end
    else
    begin
      div_ff      <= nxt_div;
      div_prev_ff <= div_ff;
    end
  end

  // External pins; input direction and buffer are set up by software beforehand
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;

  for (genvar p = 0; p < PIN_N; p++)
  begin : g_pin
    tccc_pin_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin      (ext_clk_pin[p]),
      .lvl      (pin_lvl[p]),
      .rise     (pin_rise[p]),
      .fall     (pin_fall[p])
    );
  end

  // Channels
  logic [CH_NUM-1:0] own_clr;
  logic [CH_NUM-1:0] ovf;
  logic [CH_NUM-1:0] unf;
  logic              sync_clr_any;

  // Only sync-enabled channels launch a group clear
  assign sync_clr_any = |(own_clr & sync_ff);

  for (genvar c = 0; c < CH_NUM; c++)
  begin : g_ch
    tccc_cnt_if cif ();
    tccc_src_type src;
    logic [1:0]   edge_sel;
    logic         stb;
    logic         dn;
    logic         phase_on;
    logic         pa_l;
    logic         pb_l;
    logic         pa_e;
    logic         pb_e;

    always_comb
    begin
      src      = tccc_src_of(c, ctrl_ff[c][SEL_MSB:SEL_LSB]);
      edge_sel = ctrl_ff[c][EDGE_MSB:EDGE_LSB];
      stb      = 1'b0;
      dn       = 1'b0;
      case (src)
        // Undivided clock ignores the edge field
        SRC_DIV1: stb = 1'b1;
        SRC_EXT_A, SRC_EXT_B, SRC_EXT_C, SRC_EXT_D:
          stb = edge_sel[1] ? (pin_rise[src[1:0]] | pin_fall[src[1:0]]) :
                edge_sel[0] ? pin_fall[src[1:0]] : pin_rise[src[1:0]];
        // Cascade partner is the next channel up; edge field ignored
        SRC_CASCADE: stb = (c == 1 || c == 4) ? (ovf[(c + 1) % CH_NUM] |
                                                 unf[(c + 1) % CH_NUM]) : 1'b0;
        default:
          stb = edge_sel[1] ? (int_rise[src[2:0]] | int_fall[src[2:0]]) :
                edge_sel[0] ? int_rise[src[2:0]] : int_fall[src[2:0]];
      endcase
      // Quadrature on pin pair A/B (channels 1,5) or C/D (channels 2,4)
      phase_on = (c == 1 || c == 2 || c == 4 || c == 5) && mode_ff[c];
      pa_l = (c == 2 || c == 4) ? pin_lvl[2] : pin_lvl[0];
      pb_l = (c == 2 || c == 4) ? pin_lvl[3] : pin_lvl[1];
      pa_e = (c == 2 || c == 4) ? (pin_rise[2] | pin_fall[2]) : (pin_rise[0] | pin_fall[0]);
      pb_e = (c == 2 || c == 4) ? (pin_rise[3] | pin_fall[3]) : (pin_rise[1] | pin_fall[1]);
      if (phase_on)
      begin
        stb = pa_e | pb_e;
        dn  = ~((pa_e & (pa_l ^ pb_l)) | (pb_e & ~(pa_l ^ pb_l)));
      end
      cif.cnt_up      = stb & ~dn & start_ff[c];
      cif.cnt_dn      = stb & dn & start_ff[c];
      cif.ctrl        = ctrl_ff[c];
      // Narrow channels have no C or D general register, so those events never reach them
      cif.match       = (c == 0 || c == 3) ? match_evt[4*c +: 4] :
                        {2'b00, match_evt[4*c +: 2]};
      cif.sync_en     = sync_ff[c];
      cif.buf_c       = (c == 0) ? mode_ff[MODE_BUFC0] : (c == 3) ? mode_ff[MODE_BUFC3] : 1'b0;
      cif.buf_d       = (c == 0) ? mode_ff[MODE_BUFD0] : (c == 3) ? mode_ff[MODE_BUFD3] : 1'b0;
      cif.sync_clr_in = sync_clr_any;
    end

    assign own_clr[c]  = cif.own_clr;
    assign ovf[c]      = cif.ovf;
    assign unf[c]      = cif.unf;
    assign cnt_val[c]  = cif.count;
    assign channel_counter_flat[c*CNT_W +: CNT_W] = cif.count;

    tccc_chan #(
      .CH (c)
    ) u_chan (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cif      (cif)
    );
  end

endmodule : tccc_top

/* File: tb/tccc_top_assertions.sv */
// Purpose: Port-level checks for the clock and clear control block
// Assumes: Sees tccc_top ports only; shadows rebuilt from APB writes
// Notes:   Counter checks watch channel 0, the widest clear decode
`timescale 1ns/1ps
module tccc_top_chk import tccc_pkg::*; (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Events and counters
  input wire logic [CH_NUM*4-1:0]     match_evt,
  input wire logic [CH_NUM*CNT_W-1:0] channel_counter_flat
);
  logic [7:0]  ctrl0_ff, nxt_ctrl0;
  logic [5:0]  start_ff, nxt_start;
  logic [15:0] c0;
  logic        wr;
  assign wr = psel & penable & pready & pwrite;
  assign c0 = channel_counter_flat[15:0];
  always_comb
  begin
    nxt_ctrl0 = (wr && paddr == OFS_CTRL0) ? pwdata[7:0] : ctrl0_ff;
    nxt_start = (wr && paddr == OFS_START) ? pwdata[5:0] : start_ff;
  end
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl0_ff <= 8'h00;
      start_ff <= 6'h00;
    end
    else
    begin
      ctrl0_ff <= nxt_ctrl0;
      start_ff <= nxt_start;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_access: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  chk_ctrl_upper: assert property (pready && !pwrite && paddr < 8'h18 |->
    prdata[31:8] == 24'h0)
    else $error("control read upper bits set");
  chk_reserved_zero: assert property (pready && !pwrite &&
    paddr inside {8'h04, 8'h08, 8'h10, 8'h14} |-> !prdata[7])
    else $error("reserved bit read as one");
  chk_clear_a: assert property (match_evt[0] && ctrl0_ff[7:5] == CLR_A |=> c0 == 16'h0)
    else $error("channel 0 not cleared by A");
  chk_clear_b: assert property (match_evt[1] && ctrl0_ff[7:5] == CLR_B |=> c0 == 16'h0)
    else $error("channel 0 not cleared by B");
  chk_stop_hold: assert property (ctrl0_ff[7:5] inside {3'h0, 3'h4} && !start_ff[0]
    |=> $stable(c0))
    else $error("stopped channel 0 moved");
  chk_count_step: assert property (start_ff[0] && match_evt[3:0] == 4'h0 &&
    ctrl0_ff[6:5] != 2'b11 |=> c0 == $past(c0) || c0 == $past(c0) + 16'h1)
    else $error("channel 0 stepped by more than one");
  chk_div1_rate: assert property (start_ff[0] && $past(start_ff[0]) &&
    $stable(ctrl0_ff) && ctrl0_ff[2:0] == 3'h0 && match_evt[3:0] == 4'h0 &&
    ctrl0_ff[6:5] != 2'b11 |=> c0 == $past(c0) + 16'h1)
    else $error("undivided clock missed a count");
  cov_start: cover property (wr && paddr == OFS_START);
  cov_err: cover property (pslverr);
  cov_clear: cover property (match_evt[0] && ctrl0_ff[7:5] == CLR_A);
endmodule : tccc_top_chk

bind tccc_top tccc_top_chk tccc_top_chk_inst (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .match_evt(match_evt),
  .channel_counter_flat(channel_counter_flat)
);

/* File: tb/tccc_top_bench.sv */
// Purpose: Self-checking bench for the clock and clear control block
// Assumes: APB master on core_clk, one idle cycle between transfers
// Notes:   Counter deltas span whole prescaler periods, so phase does not matter
`timescale 1ns/1ps
module tccc_top_bench;
  import tccc_pkg::*;
  logic                    core_clk = 1'b0;
  logic                    arst_n   = 1'b0;
  logic                    psel     = 1'b0;
  logic                    penable  = 1'b0;
  logic                    pwrite   = 1'b0;
  logic [7:0]              paddr    = 8'h00;
  logic [31:0]             pwdata   = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [PIN_N-1:0]        ext_clk_pin = 4'h0;
  logic [CH_NUM*4-1:0]     match_evt   = 24'h0;
  logic [CH_NUM*CNT_W-1:0] channel_counter_flat;
  int                      err_total = 0;
  int                      n_checks  = 0;
  logic [31:0]             seed = 32'd56;
  logic [7:0]              ctrl_m [CH_NUM];

  always #4 core_clk = ~core_clk;

  tccc_top tccc_top_inst (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
    .match_evt(match_evt), .channel_counter_flat(channel_counter_flat)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [15:0] cnt(input int ch);
    return channel_counter_flat[ch*16 +: 16];
  endfunction : cnt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (n >= 64) err_total++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd

  // Pins stay 4 cycles per level so the synchroniser filter accepts each one
  task automatic hold(input logic [3:0] v);
    ext_clk_pin <= v;
    repeat (4) @(posedge core_clk);
  endtask : hold

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    final_report();
  end

  initial
  begin
    logic [31:0] v;
    logic [31:0] r;
    logic        e;
    logic [15:0] a0;
    logic [15:0] a3;
    logic [7:0]  ptab [6];
    int          etab [6];
    int          n;
    int          cb;
    ptab = '{8'h01, 8'h09, 8'h11, 8'h19, 8'h10, 8'h08};
    etab = '{16, 16, 32, 32, 64, 64};
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int ch = 0; ch < CH_NUM; ch++)
    begin
      v = xs();
      ctrl_m[ch] = (ch == 0 || ch == 3) ? v[7:0] : v[7:0] & CTRL_MASK_NARROW;
      rd(OFS_CTRL0 + 8'(4 * ch), 32'h0);
      wr(OFS_CTRL0 + 8'(4 * ch), v);
      rd(OFS_CTRL0 + 8'(4 * ch), {24'h0, ctrl_m[ch]});
    end
    for (int ch = 0; ch < CH_NUM; ch++)
      rd(OFS_CTRL0 + 8'(4 * ch), {24'h0, ctrl_m[ch]});
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    $display("registers done");
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_START, 32'h0);
      wr(OFS_CTRL0, {24'h0, ptab[i]});
      wr(OFS_CTRL0 + 8'h0C, 32'h13);
      wr(OFS_START, 32'h09);
      repeat (8) @(posedge core_clk);
      a0 = cnt(0);
      a3 = cnt(3);
      repeat (64) @(posedge core_clk);
      chk({16'h0, cnt(0) - a0}, etab[i]);
      chk({16'h0, cnt(3) - a3}, 32'h2);
    end
    $display("prescale done");
    // External pin A on channel 0, edge codes 00, 01, 1x
    for (int i = 0; i < 3; i++)
    begin
      n = 3 + int'(xs() % 5);
      wr(OFS_START, 32'h0);
      wr(OFS_CTRL0, 32'h04 + 32'(i * 8));
      wr(OFS_START, 32'h01);
      a0 = cnt(0);
      repeat (n)
      begin
        hold(4'h1);
        hold(4'h0);
      end
      repeat (8) @(posedge core_clk);
      chk({16'h0, cnt(0) - a0}, (i == 2) ? 2 * n : n);
    end
    $display("pins done");
    for (int code = 0; code < 8; code++)
    begin
      if (code == 3 || code == 7) continue;
      cb = (code == 1) ? 0 : (code == 2) ? 1 : (code == 5) ? 2 : (code == 6) ? 3 : -1;
      wr(OFS_START, 32'h0);
      wr(OFS_CTRL0, 32'(code << 5));
      wr(OFS_START, 32'h01);
      for (int b = 0; b < 4; b++)
      begin
        repeat (4) @(posedge core_clk);
        match_evt[b] <= 1'b1;
        @(posedge core_clk);
        match_evt[b] <= 1'b0;
        @(posedge core_clk);
        chk({31'h0, cnt(0) === 16'h0}, {31'h0, cb == b});
      end
    end
    // Buffered C takes priority over clearing
    wr(OFS_MODE, 32'h100);
    wr(OFS_CTRL0, 32'hA0);
    repeat (4) @(posedge core_clk);
    match_evt[2] <= 1'b1;
    @(posedge core_clk);
    match_evt[2] <= 1'b0;
    @(posedge core_clk);
    chk({31'h0, cnt(0) === 16'h0}, 32'h0);
    wr(OFS_MODE, 32'h0);
    $display("clear done");
    wr(OFS_START, 32'h0);
    wr(OFS_CTRL0, 32'h20);
    wr(OFS_CTRL0 + 8'h04, 32'h60);
    wr(OFS_CTRL0 + 8'h08, 32'h60);
    wr(OFS_CTRL0 + 8'h0C, 32'hE0);
    wr(OFS_SYNC, 32'h0B);
    wr(OFS_START, 32'h0F);
    repeat (4) @(posedge core_clk);
    match_evt[0] <= 1'b1;
    @(posedge core_clk);
    match_evt[0] <= 1'b0;
    @(posedge core_clk);
    chk({cnt(1), cnt(3)}, 32'h0);
    chk({31'h0, cnt(2) === 16'h0}, 32'h0);
    $display("sync done");
    wr(OFS_START, 32'h0);
    wr(OFS_MODE, 32'h02);
    wr(OFS_CTRL0 + 8'h04, 32'h10);
    wr(OFS_START, 32'h02);
    repeat (8) @(posedge core_clk);
    a0 = cnt(1);
    n = 2 + int'(xs() % 3);
    repeat (n)
    begin
      hold(4'h1);
      hold(4'h3);
      hold(4'h2);
      hold(4'h0);
    end
    repeat (8) @(posedge core_clk);
    chk({16'h0, cnt(1) - a0}, 4 * n);
    $display("phase done");
    // Channel 2 steps down from zero in phase mode; its underflow feeds channel 1
    wr(OFS_START, 32'h0);
    wr(OFS_MODE, 32'h04);
    wr(OFS_CTRL0 + 8'h04, 32'h07);
    wr(OFS_CTRL0 + 8'h08, 32'h20);
    wr(OFS_START, 32'h06);
    match_evt[8] <= 1'b1;
    @(posedge core_clk);
    match_evt[8] <= 1'b0;
    @(posedge core_clk);
    a0 = cnt(1);
    hold(4'h8);
    hold(4'hC);
    hold(4'h4);
    hold(4'h0);
    repeat (8) @(posedge core_clk);
    chk({16'h0, cnt(1) - a0}, 32'h1);
    chk({16'h0, cnt(2)}, 32'hFFFC);
    $display("cascade done");
    final_report();
  end
endmodule : tccc_top_bench
